//--- hdl/istr_pkg.sv
`default_nettype none
package istr_pkg;
  // I/O port addresses (low 10 bits of the host I/O address)
  localparam logic [9:0] UNLOCK_PORT    = 10'h171;
  localparam logic [9:0] WR_TIMING_PORT = 10'h171;
  localparam logic [9:0] ID_PORT        = 10'h172;
  localparam logic [9:0] CONTROL_PORT   = 10'h173;
  localparam logic [9:0] STRAP_PORT     = 10'h175;
  localparam logic [9:0] MISC_PORT      = 10'h176;
  // Control register fields
  localparam int CTL_SET_B_EN   = 7;
  localparam int CTL_A_DRIVE1   = 3;
  localparam int CTL_A_DRIVE0   = 2;
  localparam logic [7:0] CTL_RESET    = 8'h01;
  localparam logic [7:0] CTL_WR_MASK  = 8'h8C;
  localparam logic [7:0] CTL_FIXED    = 8'h01;
  // Write timing fields
  localparam int WT_WIDTH_LSB = 4;
  localparam int WT_REC_LSB   = 0;
  localparam logic [7:0] WT_RESET = 8'h00;
  // Strap register fields
  localparam int ST_IRQ_BIT   = 4;
  localparam int ST_REV_LSB   = 5;
  localparam logic [7:0] ST_RESET   = 8'h80;
  localparam logic [7:0] ST_WR_MASK = 8'h8F;
  localparam logic [1:0] REV_USE_ID = 2'h3;
  // Misc register fields
  localparam int MISC_INDEX   = 0;
  localparam logic [7:0] MISC_RESET   = 8'h00;
  localparam logic [7:0] MISC_OVR_MSK = 8'h3E;
  // ID register lock bit
  localparam int ID_LOCK_BIT = 7;

  typedef enum logic [1:0] {
    SRC_DEFAULT = 2'b00,
    SRC_SET_A   = 2'b01,
    SRC_SET_B   = 2'b10
  } istr_src_t;

  typedef enum logic [1:0] {
    UL_LOCKED  = 2'b00,
    UL_FIRST   = 2'b01,
    UL_OPEN    = 2'b10
  } istr_ul_t;

  typedef struct packed {
    logic [3:0] strobe_width;
    logic [3:0] recovery;
  } istr_wtiming_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       word16;
    logic [9:0] addr;
    logic [7:0] wdata;
  } istr_io_t;
endpackage
`default_nettype wire

//--- hdl/istr_regs.sv
`default_nettype none
// How it works
// - Write timing sets A and B share one port, chosen by the index bit.
// - Timing bits 7..4 give write strobe width in clocks.
// - Timing bits 3..0 give recovery after the write strobe in clocks.
// - Set A times data writes for drives whose control bits 3..2 are set.
// - Set B times writes for other drives only while control bit 7 set.
// - Set-B enable replaces the configured default timing for other drives.
// - Set-B enable also lets misc bits 5..1 override default timing.
// - Control bit 3 puts drive 1 on set A timing.
// - Control bit 2 puts drive 0 on set A timing.
// - Control resets to 01h; reserved bits written zero, bit 0 one.
// - Strap bit 4 reads the live secondary drive interrupt level.
// - Strap bits 6..5 are read-only revision; code 11 means see ID.
// - Access opens only after two back-to-back 16-bit reads of 171h.
// - Misc bit 0 steers shared timing port: 0 set A, 1 set B.
// - Writing ID with lock bit set closes access until re-unlocked.
module istr_regs #(
  parameter logic [1:0] REVISION = 2'h1  // Arbitrary value
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  // Host I/O cycle, one cycle per access
  input  wire istr_pkg::istr_io_t io,
  output logic [7:0]             rdata,
  output logic                   rdata_hit,
  // Drive side
  input  wire logic              secondary_drive_irq_level,
  input  wire logic              drive_sel,
  // Timing applied to current data write, and access state
  output istr_pkg::istr_src_t    timing_src,
  output istr_pkg::istr_wtiming_t write_timing,
  output logic                   misc_override,
  output logic                   regs_open
);
  istr_pkg::istr_ul_t ul_r, ul_nxt;
  logic [7:0] set_a_r, set_b_r, ctl_r, strap_r, misc_r;
  logic [7:0] rdata_r, rdata_nxt;
  logic       hit_r, hit_nxt;
  logic       irq_s1_r, irq_s2_r;

  wire is_unlock_rd = io.valid && !io.write && io.word16
                      && io.addr == istr_pkg::UNLOCK_PORT;
  wire open_now  = ul_r == istr_pkg::UL_OPEN;
  wire wr_ok     = io.valid && io.write && open_now;
  wire rd_ok     = io.valid && !io.write && open_now;
  wire wr_timing = wr_ok && io.addr == istr_pkg::WR_TIMING_PORT;
  wire wr_ctl    = wr_ok && io.addr == istr_pkg::CONTROL_PORT;
  wire wr_strap  = wr_ok && io.addr == istr_pkg::STRAP_PORT;
  wire wr_misc   = wr_ok && io.addr == istr_pkg::MISC_PORT;
  wire wr_lock   = wr_ok && io.addr == istr_pkg::ID_PORT
                   && io.wdata[istr_pkg::ID_LOCK_BIT];
  wire index_b   = misc_r[istr_pkg::MISC_INDEX];
  wire set_b_en  = ctl_r[istr_pkg::CTL_SET_B_EN];
  wire drv_on_a  = drive_sel ? ctl_r[istr_pkg::CTL_A_DRIVE1]
                             : ctl_r[istr_pkg::CTL_A_DRIVE0];
  wire [7:0] strap_view = {strap_r[7], REVISION, irq_s2_r,
                           strap_r[3:0]};

  // Unlock sequencer: any other cycle between the two reads restarts it
  always_comb
  begin
    ul_nxt = ul_r;
    if (io.valid)
    begin
      case (ul_r)
        istr_pkg::UL_LOCKED:
          ul_nxt = is_unlock_rd ? istr_pkg::UL_FIRST
                                : istr_pkg::UL_LOCKED;
        istr_pkg::UL_FIRST:
          ul_nxt = is_unlock_rd ? istr_pkg::UL_OPEN
                                : istr_pkg::UL_LOCKED;
        istr_pkg::UL_OPEN:
          ul_nxt = wr_lock ? istr_pkg::UL_LOCKED
                           : istr_pkg::UL_OPEN;
        default:
          ul_nxt = istr_pkg::UL_LOCKED;
      endcase
    end
  end

  always_comb
  begin
    rdata_nxt = 8'h00;
    hit_nxt   = 1'b0;
    if (rd_ok)
    begin
      hit_nxt = 1'b1;
      case (io.addr)
        istr_pkg::WR_TIMING_PORT: rdata_nxt = index_b ? set_b_r : set_a_r;
        istr_pkg::CONTROL_PORT:   rdata_nxt = ctl_r;
        istr_pkg::STRAP_PORT:     rdata_nxt = strap_view;
        istr_pkg::MISC_PORT:      rdata_nxt = misc_r;
        default:
        begin
          rdata_nxt = 8'h00;
          hit_nxt   = 1'b0;
        end
      endcase
    end
  end

  // Interrupt level comes from a pin, so two flops before use
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_s1_r <= secondary_drive_irq_level;
      irq_s2_r <= irq_s1_r;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ul_r    <= istr_pkg::UL_LOCKED;
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
    end
    else if (clk_en)
    begin
      ul_r    <= ul_nxt;
      rdata_r <= rdata_nxt;
      hit_r   <= hit_nxt;
    end
  end

  // Writes only land while open; locked writes vanish
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      set_a_r <= istr_pkg::WT_RESET;
      set_b_r <= istr_pkg::WT_RESET;
      ctl_r   <= istr_pkg::CTL_RESET;
      strap_r <= istr_pkg::ST_RESET;
      misc_r  <= istr_pkg::MISC_RESET;
    end
    else if (clk_en)
    begin
      if (wr_timing && !index_b)
        set_a_r <= io.wdata;
      if (wr_timing && index_b)
        set_b_r <= io.wdata;
      if (wr_ctl)
        ctl_r <= (io.wdata & istr_pkg::CTL_WR_MASK)
                 | istr_pkg::CTL_FIXED;
      if (wr_strap)
        strap_r <= io.wdata & istr_pkg::ST_WR_MASK;
      if (wr_misc)
        misc_r <= io.wdata;
    end
  end

  // Timing source selection for the data write in flight
  assign timing_src = drv_on_a ? istr_pkg::SRC_SET_A :
                      set_b_en ? istr_pkg::SRC_SET_B :
                                 istr_pkg::SRC_DEFAULT;
  assign write_timing = drv_on_a ? set_a_r :
                        set_b_en ? set_b_r : 8'h00;
  // Misc setup/ready fields win over the default only with set B on
  assign misc_override = set_b_en
                         && |(misc_r & istr_pkg::MISC_OVR_MSK);
  assign regs_open = open_now;
  assign rdata     = rdata_r;
  assign rdata_hit = hit_r;

  property p_unlock_two;
    @(posedge clock) disable iff (!resetn)
      (clk_en && is_unlock_rd && ul_r == istr_pkg::UL_FIRST)
      |=> regs_open;
  endproperty
  a_unlock_two: assert property (p_unlock_two)
    else $error("two unlock reads did not open access");

  property p_break;
    @(posedge clock) disable iff (!resetn)
      (clk_en && io.valid && !is_unlock_rd && ul_r == istr_pkg::UL_FIRST)
      |=> !regs_open;
  endproperty
  a_break: assert property (p_break)
    else $error("interleaved cycle did not cancel unlock");

  property p_lock;
    @(posedge clock) disable iff (!resetn)
      (clk_en && wr_lock) |=> !regs_open;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock write left access open");

  property p_locked_ctl;
    @(posedge clock) disable iff (!resetn)
      (!regs_open) |=> $stable(ctl_r) && $stable(set_a_r)
                       && $stable(set_b_r);
  endproperty
  a_locked_ctl: assert property (p_locked_ctl)
    else $error("register changed while locked");

  property p_ctl_fixed;
    @(posedge clock) disable iff (!resetn)
      ctl_r[0] && ctl_r[1] == 1'b0 && ctl_r[6:4] == 3'h0;
  endproperty
  a_ctl_fixed: assert property (p_ctl_fixed)
    else $error("control reserved bits wrong");

  property p_src_a;
    @(posedge clock) disable iff (!resetn)
      drv_on_a |-> timing_src == istr_pkg::SRC_SET_A
                   && write_timing == set_a_r;
  endproperty
  a_src_a: assert property (p_src_a)
    else $error("set A not applied");

  property p_src_b;
    @(posedge clock) disable iff (!resetn)
      (!drv_on_a) |-> (timing_src == istr_pkg::SRC_SET_B) == set_b_en;
  endproperty
  a_src_b: assert property (p_src_b)
    else $error("set B selection wrong");

  property p_irq;
    @(posedge clock) disable iff (!resetn)
      (clk_en && rd_ok && io.addr == istr_pkg::STRAP_PORT)
      |=> rdata[istr_pkg::ST_IRQ_BIT] == $past(irq_s2_r)
          && rdata[6:5] == REVISION;
  endproperty
  a_irq: assert property (p_irq)
    else $error("strap read wrong");

  c_unlock: cover property (@(posedge clock) disable iff (!resetn)
    !regs_open ##1 regs_open);
  c_set_b: cover property (@(posedge clock) disable iff (!resetn)
    timing_src == istr_pkg::SRC_SET_B);
  c_relock: cover property (@(posedge clock) disable iff (!resetn)
    regs_open ##1 !regs_open);
endmodule
`default_nettype wire

//--- testbench/istr_drive_model.sv
`default_nettype none
module istr_drive_model (
  // Clock
  input  wire logic clock,
  // Drive side
  output logic      drive_sel,
  output logic      secondary_drive_irq_level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    drive_sel = 1'b0;
    secondary_drive_irq_level = 1'b0;
  end
  task automatic pick(input logic d);
    @(negedge clock);
    drive_sel = d;
    @(negedge clock);
  endtask
  // Pin is asynchronous, so move it off any edge
  task automatic irq(input logic v);
    #3;
    secondary_drive_irq_level = v;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       w;
    logic       w16;
    logic [9:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic       h;
  } istr_row_t;
  logic                    clock = 1'b0;
  logic                    resetn = 1'b0;
  logic                    clk_en = 1'b1;
  istr_pkg::istr_io_t      io = '0;
  logic [7:0]              rdata;
  logic                    rdata_hit;
  logic                    dsel;
  logic                    dirq;
  istr_pkg::istr_src_t     timing_src;
  istr_pkg::istr_wtiming_t write_timing;
  logic                    misc_override;
  logic                    regs_open;
  logic [7:0]              rd;
  logic                    hit;
  int                      bad_count = 0;
  int                      num_checks = 0;
  istr_row_t rows [19] = '{
    '{1'b0, 1'b1, 10'h171, 8'h00, 8'h00, 1'b0},
    '{1'b0, 1'b1, 10'h171, 8'h00, 8'h00, 1'b0},
    '{1'b0, 1'b0, 10'h173, 8'h00, 8'h01, 1'b1},
    '{1'b0, 1'b0, 10'h175, 8'h00, 8'hA0, 1'b1},
    '{1'b0, 1'b0, 10'h171, 8'h00, 8'h00, 1'b1},
    '{1'b1, 1'b0, 10'h171, 8'hA5, 8'h00, 1'b0},
    '{1'b1, 1'b0, 10'h176, 8'h01, 8'h00, 1'b0},
    '{1'b1, 1'b0, 10'h171, 8'h3C, 8'h00, 1'b0},
    '{1'b0, 1'b0, 10'h171, 8'h00, 8'h3C, 1'b1},
    '{1'b1, 1'b0, 10'h176, 8'h00, 8'h00, 1'b0},
    '{1'b0, 1'b0, 10'h171, 8'h00, 8'hA5, 1'b1},
    '{1'b1, 1'b0, 10'h173, 8'h8D, 8'h00, 1'b0},
    '{1'b0, 1'b0, 10'h173, 8'h00, 8'h8D, 1'b1},
    '{1'b1, 1'b0, 10'h175, 8'h82, 8'h00, 1'b0},
    '{1'b0, 1'b0, 10'h175, 8'h00, 8'hA2, 1'b1},
    '{1'b0, 1'b0, 10'h174, 8'h00, 8'h00, 1'b0},
    '{1'b1, 1'b0, 10'h172, 8'h80, 8'h00, 1'b0},
    '{1'b1, 1'b0, 10'h173, 8'h00, 8'h00, 1'b0},
    '{1'b0, 1'b0, 10'h173, 8'h00, 8'h00, 1'b0}
  };
  always #10 clock = ~clock;
  istr_regs DUT (
    .clock(clock), .resetn(resetn), .clk_en(clk_en), .io(io),
    .rdata(rdata), .rdata_hit(rdata_hit),
    .secondary_drive_irq_level(dirq), .drive_sel(dsel),
    .timing_src(timing_src), .write_timing(write_timing),
    .misc_override(misc_override), .regs_open(regs_open)
  );
  istr_drive_model drv (
    .clock(clock), .drive_sel(dsel), .secondary_drive_irq_level(dirq)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_sel(input logic [1:0] s, input logic [7:0] t);
    chk({6'h00, timing_src}, {6'h00, s});
    chk(write_timing, t);
  endtask
  // Leaves valid high so back-to-back cycles stay back to back
  task automatic op(input logic w, input logic w16, input logic [9:0] a,
                    input logic [7:0] d);
    io = '{1'b1, w, w16, a, d};
    @(negedge clock);
    rd = rdata;
    hit = rdata_hit;
  endtask
  task automatic idle();
    io.valid = 1'b0;
    @(negedge clock);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
    idle();
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    op(1'b0, 1'b0, a, 8'h00);
    idle();
    chk(rd, e);
  endtask
  task automatic unlock();
    op(1'b0, 1'b1, 10'h171, 8'h00);
    op(1'b0, 1'b1, 10'h171, 8'h00);
    idle();
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    chk({7'h00, regs_open}, 8'h00);
    foreach (rows[i])
    begin
      op(rows[i].w, rows[i].w16, rows[i].a, rows[i].d);
      chk(rd, rows[i].e);
      chk({7'h00, hit}, {7'h00, rows[i].h});
    end
    idle();
    unlock();
    rdc(10'h173, 8'h8D);
    wr(10'h173, 8'h05);
    drv.pick(1'b0);
    chk_sel(2'h1, 8'hA5);
    drv.pick(1'b1);
    chk_sel(2'h0, 8'h00);
    wr(10'h173, 8'h85);
    chk_sel(2'h2, 8'h3C);
    drv.pick(1'b0);
    chk_sel(2'h1, 8'hA5);
    wr(10'h173, 8'h89);
    chk_sel(2'h2, 8'h3C);
    drv.pick(1'b1);
    chk_sel(2'h1, 8'hA5);
    chk({7'h00, misc_override}, 8'h00);
    wr(10'h176, 8'h3E);
    chk({7'h00, misc_override}, 8'h01);
    wr(10'h173, 8'h09);
    chk({7'h00, misc_override}, 8'h00);
    drv.irq(1'b1);
    repeat (4) @(negedge clock);
    rdc(10'h175, 8'hB2);
    // Foreign cycle between the two reads must spoil the unlock
    wr(10'h172, 8'h80);
    op(1'b0, 1'b1, 10'h171, 8'h00);
    op(1'b1, 1'b0, 10'h176, 8'h00);
    op(1'b0, 1'b1, 10'h171, 8'h00);
    idle();
    chk({7'h00, regs_open}, 8'h00);
    resetn = 1'b0;
    @(negedge clock);
    chk({7'h00, regs_open}, 8'h00);
    resetn = 1'b1;
    unlock();
    chk({7'h00, regs_open}, 8'h01);
    rdc(10'h173, 8'h01);
    // Frozen clock enable must drop the control write and keep access open
    clk_en = 1'b0;
    op(1'b1, 1'b0, 10'h173, 8'h85);
    idle();
    clk_en = 1'b1;
    rdc(10'h173, 8'h01);
    chk({7'h00, regs_open}, 8'h01);
    final_report();
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
